// ### rtl/fpu_math_stage.sv
// Second execute stage of the two-cycle math lanes, holding issued operations for one cycle.
`timescale 1ns/1ps
`default_nettype none
module fpu_math_stage
  import fpu_pipe_pkg::*;
#(
  parameter int LANES = MATH_LANES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire math_issue_t [LANES-1:0] i_issue,
  input wire logic [LANES-1:0][DATA_W-1:0] i_arith_result,
  output math_issue_t [LANES-1:0] o_arith,
  output reg_write_t [LANES-1:0] o_write
);

  typedef struct packed {
    math_issue_t [LANES-1:0] lane;
  } stage_state_t;

  stage_state_t state_q;
  stage_state_t state_d;

  // The register file owner writes both lanes at one edge, so more lanes would need more ports.
  if (LANES != MATH_LANES) begin : g_lane_check
    $error("fpu_math_stage supports exactly MATH_LANES lanes");
  end

  // A stall freezes the stage so the result lands aligned with the host pipeline.
  always_comb begin
    state_d = state_q;
    if (!i_stall) begin
      state_d.lane = i_issue;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Each lane retires with the external arithmetic result in its second cycle.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign o_arith[i] = state_q.lane[i];
    assign o_write[i].en = state_q.lane[i].en;
    assign o_write[i].dst = state_q.lane[i].dst;
    assign o_write[i].data = i_arith_result[i];

    lane_retire_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_issue[i].en && !i_stall) |=> (o_write[i].en && o_write[i].dst == $past(i_issue[i].dst)))
      else $error("math lane did not reach its second cycle");

    lane_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_stall && o_arith[i].en) |=> (o_arith[i].en && $stable(o_arith[i])))
      else $error("math lane moved during a stall");
  end

endmodule
`default_nettype wire

// ### rtl/fpu_parallel_issue.sv
// Parallel-opcode issue, register file and delay-slot timing of the floating-point unit.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - One opcode starts up to three operations together: two math and one side.
// - Math takes two cycles, move takes one.
// - Paired math results land together, two cycles.
// - Second operation reads pre-write register value.
// - Math reads register before paired move.
// - Slot instructions run normally, concurrently.
// - New instruction accepted every cycle.
// - Host stalls freeze this unit too.
module fpu_parallel_issue
  import fpu_pipe_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire instr_t i_instr,
  input wire logic [MATH_LANES-1:0][DATA_W-1:0] i_arith_result,
  output logic o_issue_ready,
  output math_issue_t [MATH_LANES-1:0] o_arith,
  output store_t o_store,
  output logic [FLAGS_W-1:0] o_fp_status_flags,
  output logic [NUM_REGS-1:0][DATA_W-1:0] o_regs
);

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [FLAGS_W-1:0] flags;
    store_t store;
  } state_t;

  state_t state_q;
  state_t state_d;
  math_issue_t [MATH_LANES-1:0] issue;
  reg_write_t [MATH_LANES-1:0] retire;
  math_op_t [MATH_LANES-1:0] math_ops;
  logic take;

  // Every check below runs on the system clock and stays quiet while reset is held.
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // The unit never interlocks: only the host stall holds an instruction back.
  assign o_issue_ready = !i_stall;
  assign take = i_instr.valid && !i_stall;
  assign math_ops[0] = i_instr.math0;
  assign math_ops[1] = i_instr.math1;

  // Operands come from the registers as they stand now, before any write of this opcode.
  // That is what lets the paired move or math reuse a register the other half overwrites.
  always_comb begin
    for (int i = 0; i < MATH_LANES; i++) begin
      issue[i].en = take && math_ops[i].en;
      issue[i].fn = math_ops[i].fn;
      issue[i].dst = math_ops[i].dst;
      issue[i].a = state_q.regs[math_ops[i].src_a];
      issue[i].b = state_q.regs[math_ops[i].src_b];
    end
  end

  // The second execute cycle sits in its own module so that the lane count stays one parameter.
  fpu_math_stage #(
    .LANES(MATH_LANES)
  ) u_math_stage (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_stall(i_stall),
    .i_issue(issue),
    .i_arith_result(i_arith_result),
    .o_arith(o_arith),
    .o_write(retire)
  );

  // Retiring math writes first, then the newly taken side operation, which is the later instruction.
  // Two writes to one register in the same edge are left undefined by the stream, so no check is made.
  always_comb begin
    state_d = state_q;
    // During a stall nothing moves, so a retiring lane simply waits for the next free edge.
    if (!i_stall) begin
      state_d.store.valid = 1'b0;
      // Lane 1 is looked at last, so its result decides the flags of a pair.
      for (int i = 0; i < MATH_LANES; i++) begin
        if (retire[i].en) begin
          state_d.regs[retire[i].dst] = retire[i].data;
          state_d.flags[FLAG_NEG_BIT] = retire[i].data[SIGN_BIT];
          state_d.flags[FLAG_ZERO_BIT] = (retire[i].data[SIGN_BIT-1:0] == '0);
        end
      end
      // Side operations read the registers as they stood before this edge.
      if (i_instr.valid) begin
        case (i_instr.side.kind)
          word_move_op: begin
            state_d.regs[i_instr.side.reg_idx] = i_instr.side.data;
          end
          word_store_op: begin
            state_d.store.valid = 1'b1;
            state_d.store.data = state_q.regs[i_instr.side.reg_idx];
          end
          flag_set_op: begin
            state_d.flags = i_instr.side.data[FLAGS_W-1:0];
          end
          flags_to_int_status_op: begin
            state_d.store.valid = 1'b1;
            state_d.store.data = {{(DATA_W-FLAGS_W){1'b0}}, state_q.flags};
          end
          default: begin
            state_d.store.valid = 1'b0;
          end
        endcase
      end
    end
  end

  // Reset clears the register file and the flags, and leaves the store port idle.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q.regs <= {NUM_REGS{REG_RESET}};
      state_q.flags <= FLAGS_RESET;
      state_q.store <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // All data outputs come straight from flops, so the host never sees a half-updated register file.
  assign o_store = state_q.store;
  assign o_fp_status_flags = state_q.flags;
  assign o_regs = state_q.regs;

  // Helpers that tell whether a retiring math write collides with a move, or for lane 0 with a lane 1 write, in the same edge.
  logic move_hit;
  logic math0_clear;
  assign move_hit = take && i_instr.side.kind == word_move_op;
  assign math0_clear = !(move_hit && i_instr.side.reg_idx == retire[0].dst) &&
    !(retire[1].en && retire[1].dst == retire[0].dst);
  // Lane 1 writes after lane 0, so only a same-edge move can overwrite its result.
  logic math1_clear;
  logic flag_hold;
  logic store_next;
  assign math1_clear = !(move_hit && i_instr.side.reg_idx == retire[1].dst);
  assign flag_hold = take && i_instr.side.kind == flag_set_op;
  assign store_next = take && (i_instr.side.kind == word_store_op || i_instr.side.kind == flags_to_int_status_op);

  pair_start_a: assert property (take && i_instr.math0.en && i_instr.math1.en
    |=> o_arith[0].en && o_arith[1].en)
    else $error("paired math operations did not start together");

  move_one_cycle_a: assert property (move_hit && !(retire[0].en && retire[0].dst == i_instr.side.reg_idx)
    && !(retire[1].en && retire[1].dst == i_instr.side.reg_idx)
    |=> o_regs[$past(i_instr.side.reg_idx)] == $past(i_instr.side.data))
    else $error("move target not valid after one cycle");

  math_two_cycle_a: assert property (issue[0].en && !i_stall ##1 (!i_stall && math0_clear)
    |=> o_regs[$past(retire[0].dst)] == $past(i_arith_result[0]))
    else $error("math result not valid two cycles after issue");

  store_old_value_a: assert property (take && i_instr.side.kind == word_store_op
    |=> o_store.valid && o_store.data == $past(state_q.regs[i_instr.side.reg_idx]))
    else $error("store did not see the value before the write");

  math_old_source_a: assert property (take && i_instr.math0.en
    |=> o_arith[0].a == $past(state_q.regs[i_instr.math0.src_a]))
    else $error("math operand not taken before the paired move");

  // A pending lane never blocks the next opcode: the follower starts at the very next edge.
  always_ready_a: assert property (o_arith[0].en && take && i_instr.math0.en
    |-> o_issue_ready ##1 (o_arith[0].en && o_arith[0].dst == $past(i_instr.math0.dst)))
    else $error("issue refused while math pending");

  stall_freeze_a: assert property (i_stall |=> $stable(o_regs) && $stable(o_fp_status_flags)
    && $stable(o_store))
    else $error("state changed during a host stall");

  flag_set_a: assert property (take && i_instr.side.kind == flag_set_op
    |=> o_fp_status_flags == $past(i_instr.side.data[FLAGS_W-1:0]))
    else $error("flag set not applied");

  lane1_two_cycle_a: assert property (issue[1].en ##1 (!i_stall && math1_clear)
    |=> o_regs[$past(retire[1].dst)] == $past(i_arith_result[1]))
    else $error("second lane result not valid two cycles after issue");

  // The store port carries one word per store or flags-out and then falls idle.
  store_pulse_a: assert property (o_store.valid && !i_stall && !store_next |=> !o_store.valid)
    else $error("store port held a stale word");

  flags_out_a: assert property (take && i_instr.side.kind == flags_to_int_status_op
    |=> o_store.valid && o_store.data == {{(DATA_W-FLAGS_W){1'b0}}, $past(o_fp_status_flags)})
    else $error("flags not copied out zero extended");

  // The flags follow the last retiring result unless a flag set lands at the same edge.
  math_flags_a: assert property (retire[1].en && !i_stall && !flag_hold
    |=> o_fp_status_flags[FLAG_NEG_BIT] == $past(retire[1].data[SIGN_BIT]))
    else $error("flags do not follow the retiring result");

  stall_lanes_a: assert property (i_stall |=> $stable(o_arith))
    else $error("a math lane moved during a host stall");

  slot_move_a: assert property (o_arith[0].en && move_hit
    |=> o_regs[$past(i_instr.side.reg_idx)] == $past(i_instr.side.data))
    else $error("slot move did not run beside the pending math");

  // Covers show that the bench reaches paired issue, filled slots, flags-out and a stall on a pending lane.
  pair_math_c: cover property (take && i_instr.math0.en && i_instr.math1.en);
  math_move_c: cover property (take && i_instr.math0.en && i_instr.side.kind == word_move_op);
  slot_fill_c: cover property (o_arith[0].en && take && i_instr.side.kind != side_none);
  stall_pending_c: cover property (o_arith[0].en && i_stall ##1 !i_stall);
  flags_out_c: cover property (take && i_instr.side.kind == flags_to_int_status_op);

endmodule
`default_nettype wire

// ### rtl/fpu_pipe_pkg.sv
// Shared constants and carrier types for the floating-point parallel issue pipeline.
package fpu_pipe_pkg;

  localparam int NUM_REGS = 8;
  localparam int REG_IDX_W = 3;
  localparam int DATA_W = 32;
  localparam int MATH_LANES = 2;
  localparam int FLAGS_W = 2;
  localparam int FLAG_NEG_BIT = 0;
  localparam int FLAG_ZERO_BIT = 1;
  localparam int SIGN_BIT = 31;
  localparam int MATH_LATENCY = 2;
  localparam int MOVE_LATENCY = 1;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 2'h0;

  typedef enum logic [1:0] {
    float_add_op,
    float_subtract_op,
    float_multiply_op
  } math_fn_t;

  typedef enum logic [2:0] {
    side_none,
    word_move_op,
    word_store_op,
    flag_set_op,
    flags_to_int_status_op
  } side_kind_t;

  typedef struct packed {
    logic en;
    math_fn_t fn;
    logic [REG_IDX_W-1:0] dst;
    logic [REG_IDX_W-1:0] src_a;
    logic [REG_IDX_W-1:0] src_b;
  } math_op_t;

  typedef struct packed {
    side_kind_t kind;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [DATA_W-1:0] data;
  } side_op_t;

  typedef struct packed {
    logic valid;
    math_op_t math0;
    math_op_t math1;
    side_op_t side;
  } instr_t;

  typedef struct packed {
    logic en;
    math_fn_t fn;
    logic [REG_IDX_W-1:0] dst;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
  } math_issue_t;

  typedef struct packed {
    logic en;
    logic [REG_IDX_W-1:0] dst;
    logic [DATA_W-1:0] data;
  } reg_write_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } store_t;

endpackage

// ### sim/fpu_host_model.sv
// Behavioural arithmetic partner that answers the two math lanes of the issue pipeline.
`timescale 1ns/1ps
`default_nettype none
module fpu_host_model
  import fpu_pipe_pkg::*;
(
  input wire math_issue_t [MATH_LANES-1:0] i_lanes,
  output logic [MATH_LANES-1:0][DATA_W-1:0] o_result
);
  // Integer arithmetic stands in for the float datapath, since only timing and operand routing are under test.
  // An idle lane shows the inverse of its operand, never a held answer, so a stale capture cannot pass.
  always_comb begin
    for (int k = 0; k < MATH_LANES; k++) begin
      case (i_lanes[k].fn)
        float_add_op: o_result[k] = i_lanes[k].a + i_lanes[k].b;
        float_subtract_op: o_result[k] = i_lanes[k].a - i_lanes[k].b;
        default: o_result[k] = i_lanes[k].a * i_lanes[k].b;
      endcase
      if (!i_lanes[k].en) begin
        o_result[k] = ~i_lanes[k].a;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/fpu_parallel_op_delay_slots_tb_top.sv
// Self-checking bench for the parallel issue pipeline: table of instructions, then stall and reset cases.
`timescale 1ns/1ps
`default_nettype none
module fpu_parallel_op_delay_slots_tb_top
  import fpu_pipe_pkg::*;
;
  typedef struct packed {instr_t i; logic [3:0] w; logic [31:0] v;} row_t;
  localparam math_op_t NM = '0;
  localparam side_op_t SN = '0;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_stall = 1'b0;
  instr_t i_instr = '0;
  logic [MATH_LANES-1:0][DATA_W-1:0] res;
  logic rdy;
  math_issue_t [MATH_LANES-1:0] arith;
  store_t st;
  logic [FLAGS_W-1:0] flg;
  logic [NUM_REGS-1:0][DATA_W-1:0] regs;
  row_t rows [15];
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  fpu_parallel_issue i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_stall(i_stall), .i_instr(i_instr),
    .i_arith_result(res), .o_issue_ready(rdy), .o_arith(arith), .o_store(st), .o_fp_status_flags(flg), .o_regs(regs));
  fpu_host_model i_host (.i_lanes(arith), .o_result(res));

  // A 100 ns clock, and a ceiling well above the thirty or so cycles that the tests need.
  always #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 400) begin
      errors++;
      give_verdict();
    end
  end

  function automatic math_op_t mth(math_fn_t f, logic [2:0] d, logic [2:0] a, logic [2:0] b);
    return '{1'b1, f, d, a, b};
  endfunction
  function automatic side_op_t sd(side_kind_t k, logic [2:0] r, logic [31:0] x);
    return '{k, r, x};
  endfunction
  function automatic instr_t ins(math_op_t m0, math_op_t m1, side_op_t s);
    return '{1'b1, m0, m1, s};
  endfunction

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Each row is checked after its own edge: w 0-7 a register, 8 the store port, 9 the flags.
  // Every slot row avoids the pending destination and flag access, as the stream must.
  initial begin
    rows[0] = '{ins(NM, NM, sd(word_move_op, 3'h1, 32'h0000_0005)), 4'h1, 32'h0000_0005};
    rows[1] = '{ins(NM, NM, sd(word_move_op, 3'h2, 32'h0000_0003)), 4'h2, 32'h0000_0003};
    rows[2] = '{ins(mth(float_add_op, 3'h3, 3'h1, 3'h2), NM, sd(word_move_op, 3'h1, 32'h0000_000a)), 4'h1, 32'h0000_000a};
    rows[3] = '{ins(NM, NM, sd(word_move_op, 3'h4, 32'h0000_0007)), 4'h3, 32'h0000_0008};
    rows[4] = '{ins(mth(float_multiply_op, 3'h5, 3'h1, 3'h2), mth(float_subtract_op, 3'h6, 3'h4, 3'h2), SN), 4'h4,
      32'h0000_0007};
    rows[5] = '{'0, 4'h5, 32'h0000_001e};
    rows[6] = '{ins(NM, NM, sd(word_store_op, 3'h6, 32'h0000_0000)), 4'h8, 32'h0000_0004};
    rows[7] = '{ins(mth(float_add_op, 3'h2, 3'h1, 3'h1), NM, sd(word_store_op, 3'h2, 32'h0000_0000)), 4'h8, 32'h0000_0003};
    rows[8] = '{'0, 4'h2, 32'h0000_0014};
    rows[9] = '{ins(NM, NM, sd(flag_set_op, 3'h0, 32'h0000_0003)), 4'h9, 32'h0000_0003};
    rows[10] = '{ins(NM, NM, sd(flags_to_int_status_op, 3'h0, 32'h0000_0000)), 4'h8, 32'h0000_0003};
    rows[11] = '{ins(mth(float_subtract_op, 3'h6, 3'h1, 3'h2), NM, SN), 4'h9, 32'h0000_0003};
    rows[12] = '{ins(mth(float_add_op, 3'h5, 3'h1, 3'h1), NM, SN), 4'h9, 32'h0000_0001};
    rows[13] = '{'0, 4'h6, 32'hffff_fff6};
    rows[14] = '{'0, 4'h5, 32'h0000_0014};
    repeat (10) @(posedge i_clk_sys);
    #2;
    i_rst = 1'b0;
    chk("reset_reg", regs[3], 32'h0000_0000);
    chk("reset_flags", 32'(flg), 32'h0000_0000);
    chk("reset_store", 32'(st.valid), 32'h0000_0000);
    foreach (rows[n]) begin
      i_instr = rows[n].i;
      @(posedge i_clk_sys);
      #2;
      chk("ready", 32'(rdy), 32'h0000_0001);
      if (rows[n].w != 4'h8) begin
        chk("store_idle", 32'(st.valid), 32'h0000_0000);
      end
      if (rows[n].w < 4'h8) begin
        chk("reg", regs[rows[n].w[2:0]], rows[n].v);
      end else if (rows[n].w == 4'h8) begin
        chk("store_valid", 32'(st.valid), 32'h0000_0001);
        chk("store", st.data, rows[n].v);
      end else begin
        chk("flags", 32'(flg), rows[n].v);
      end
    end
    // A stall in mid-operation must freeze the lane and ignore the offered instruction.
    i_instr = ins(mth(float_add_op, 3'h7, 3'h1, 3'h2), NM, SN);
    @(posedge i_clk_sys);
    #2;
    i_stall = 1'b1;
    i_instr = ins(NM, NM, sd(word_move_op, 3'h0, 32'h0000_00ff));
    repeat (3) begin
      @(posedge i_clk_sys);
      #2;
      chk("stall_ready", 32'(rdy), 32'h0000_0000);
      chk("stall_hold", regs[7], 32'h0000_0000);
      chk("stall_lane", arith[0].a, 32'h0000_000a);
    end
    i_stall = 1'b0;
    i_instr = '0;
    @(posedge i_clk_sys);
    #2;
    chk("stall_done", regs[7], 32'h0000_001e);
    chk("stall_ignored", regs[0], 32'h0000_0000);
    // A second reset in mid-cycle must clear state without waiting for an edge.
    i_rst = 1'b1;
    #10;
    chk("rerst_reg", regs[7], 32'h0000_0000);
    chk("rerst_lane", 32'(arith[0].en), 32'h0000_0000);
    @(posedge i_clk_sys);
    #2;
    i_rst = 1'b0;
    i_instr = ins(NM, NM, sd(word_move_op, 3'h7, 32'h0000_0011));
    @(posedge i_clk_sys);
    #2;
    chk("rerst_take", regs[7], 32'h0000_0011);
    i_instr = '0;
    give_verdict();
  end
endmodule
`default_nettype wire
